// file: pkg/dmioc_consts.vh
// Constants for the mixed digital I/O and counter unit
`ifndef DMIOC_CONSTS_VH
`define DMIOC_CONSTS_VH
// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define DMIOC_CLK_MHZ 100
`define DMIOC_TICK_US 100
`define DMIOC_TICK_CYCLES (`DMIOC_TICK_US * `DMIOC_CLK_MHZ)
`define DMIOC_GATE_REF_US 1
`define DMIOC_GATE_REF_CYCLES (`DMIOC_GATE_REF_US * `DMIOC_CLK_MHZ)
`define DMIOC_FAULT_US 10
`define DMIOC_FAULT_CYCLES (`DMIOC_FAULT_US * `DMIOC_CLK_MHZ)
`define DMIOC_SAMPLE_OFFSET 16
// ----------------------------------------
// Filter and gate limits
// ----------------------------------------
`define DMIOC_DELAY_MAX 8'hFA
`define DMIOC_GATE_SAT 16'hFFFF
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DMIOC_OFS_INPUT 14'h0000
`define DMIOC_OFS_OUTPUT 14'h0002
`define DMIOC_OFS_COUNT1 14'h0004
`define DMIOC_OFS_COUNT2 14'h0006
`define DMIOC_OFS_RAW 14'h000A
`define DMIOC_OFS_DIR 14'h0010
`define DMIOC_OFS_FILTER 14'h0012
`define DMIOC_OFS_CCFG1 14'h0014
`define DMIOC_OFS_CCFG2 14'h0016
`define DMIOC_OFS_LATCH 14'h001A
`define DMIOC_OFS_ACK 14'h001C
`define DMIOC_OFS_FAULT 14'h001E
`define DMIOC_OFS_SUPPLY 14'h2004
// ----------------------------------------
// Counter config fields and reset values
// ----------------------------------------
`define DMIOC_CCFG_GATE_BIT 0
`define DMIOC_CCFG_CLR_BIT 5
`define DMIOC_RST_BYTE 8'h00
`define DMIOC_RST_WORD 16'h0000
`endif

// file: rtl/dmioc_unit.v
// Eight-channel mixed digital I/O with filter, edge latch, counters and monitoring
`timescale 1ns/1ps
// ----------------------------------------
// Summary of operation
// [R1] Eight channels, each set as input or output by a direction mask.
// [R2] Unfiltered inputs snapshot at a fixed offset after each network cycle mark.
// [R3] Filtered inputs snapshot at the same fixed offset in the same cycle.
// [R4] Filter runs on a free local 200 us sample base, not the network.
// [R5] Each input has its own filter dropping pulses shorter than the delay.
// [R6] Delay setting counts in 100 us units.
// [R7] Software should program even delay values only.
// [R8] Delay 0 bypasses the filter; values above 250 act as 250.
// [R9] Rising edges per input latch into a flag at 200 us resolution.
// [R10] Latch is reset-dominant: acknowledge beats a simultaneous edge.
// [R11] Host clears latches by setting matching bits in the acknowledge byte.
// [R12] Two counter channels, each event counter or gate measurement.
// [R13] Event mode counts every falling edge of the counter input.
// [R14] Event count snapshot at the fixed offset in the network cycle.
// [R15] Gate mode times rising to falling edge with an internal reference.
// [R16] Gate time beyond range reads as FFFF.
// [R17] Finished gate time moves to the result register on the falling edge.
// [R18] Gate input must stay low over 100 us between measurements.
// [R19] Gate mode on one channel only; channel 1 wins if both set.
// [R20] Each output compares its pin state against the driven target.
// [R21] A change of commanded output state clears that channel's monitor.
// [R22] One status bit per output: 0 healthy, 1 short or overload.
// [R23] Any monitor status change raises an unsolicited error event.
// [R24] Supply flag 0 inside 18-30 V window, 1 outside it.
// [R25] One 100 us tick drives sampling; inputs sampled every second tick.
// [R26] Event counter is 16 bits, wraps, cleared by reset.
// ----------------------------------------
`include "dmioc_consts.vh"

module dmioc_unit #(
  parameter NCH = 8,
  parameter TICK_CYCLES = `DMIOC_TICK_CYCLES,
  parameter GATE_REF_CYCLES = `DMIOC_GATE_REF_CYCLES,
  parameter FAULT_CYCLES = `DMIOC_FAULT_CYCLES,
  parameter SAMPLE_OFFSET = `DMIOC_SAMPLE_OFFSET
) (
  input wire clk,
  input wire sys_rst,
  input wire [13:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire net_cycle_mark,
  input wire [NCH-1:0] io_pin_in,
  output wire [NCH-1:0] io_pin_out,
  output wire [NCH-1:0] io_pin_oe,
  input wire supply_under,
  input wire supply_over,
  output reg fault_event
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins and supply comparators are asynchronous: two stages first
  reg [NCH-1:0] pin_meta;
  reg [NCH-1:0] pin_sync;
  reg [1:0] sup_meta;
  reg [1:0] sup_sync;
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_meta <= {NCH{1'b0}};
      pin_sync <= {NCH{1'b0}};
      sup_meta <= 2'b00;
      sup_sync <= 2'b00;
    end else begin
      pin_meta <= io_pin_in;
      pin_sync <= pin_meta;
      sup_meta <= {supply_over, supply_under};
      sup_sync <= sup_meta;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  reg [NCH-1:0] channel_direction_mask;
  reg [NCH-1:0] out_target;
  reg [7:0] filter_delay;
  reg [7:0] ccfg1;
  reg [7:0] ccfg2;
  reg [NCH-1:0] edge_capture_ack;
  always @(posedge clk) begin
    if (sys_rst) begin
      channel_direction_mask <= {NCH{1'b0}};
      out_target <= {NCH{1'b0}};
      filter_delay <= `DMIOC_RST_BYTE;
      ccfg1 <= `DMIOC_RST_BYTE;
      ccfg2 <= `DMIOC_RST_BYTE;
      edge_capture_ack <= {NCH{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `DMIOC_OFS_DIR: channel_direction_mask <= reg_wdata[NCH-1:0];
        `DMIOC_OFS_OUTPUT: out_target <= reg_wdata[NCH-1:0];
        `DMIOC_OFS_FILTER: filter_delay <= reg_wdata[7:0];
        `DMIOC_OFS_CCFG1: ccfg1 <= reg_wdata[7:0];
        `DMIOC_OFS_CCFG2: ccfg2 <= reg_wdata[7:0];
        `DMIOC_OFS_ACK: edge_capture_ack <= reg_wdata[NCH-1:0];
        // Read-only offsets land here and are ignored
        default: ccfg1 <= ccfg1;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Next-state view lets the drive flop update on the write edge itself
  wire wr_dir = reg_wr & (reg_addr == `DMIOC_OFS_DIR);
  wire wr_out = reg_wr & (reg_addr == `DMIOC_OFS_OUTPUT);
  wire [NCH-1:0] next_mask = wr_dir ? reg_wdata[NCH-1:0] : channel_direction_mask;
  wire [NCH-1:0] next_target = wr_out ? reg_wdata[NCH-1:0] : out_target;
  reg [NCH-1:0] pin_drive;
  // Registered drive keeps the pad free of gating glitches
  always @(posedge clk) begin
    if (sys_rst)
      pin_drive <= {NCH{1'b0}};
    else
      pin_drive <= next_target & next_mask; // R1
  end
  // Outputs drive only where the mask selects output
  assign io_pin_out = pin_drive; // R1
  assign io_pin_oe = channel_direction_mask; // R1

  // ----------------------------------------
  // Local time base
  // ----------------------------------------
  reg [31:0] tick_cnt;
  reg tick_phase;
  wire tick = (tick_cnt == TICK_CYCLES - 1);
  // Every second tick gives the 200 us filter and latch grid
  wire sample_tick = tick & tick_phase;
  always @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 32'h00000000;
      tick_phase <= 1'b0;
    end else begin
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001; // R25
      if (tick)
        tick_phase <= ~tick_phase; // R25 R4
    end
  end

  // Clamped delay, counted in 100 us ticks
  wire [7:0] delay_eff = (filter_delay > `DMIOC_DELAY_MAX) ? `DMIOC_DELAY_MAX
                         : filter_delay; // R8 R6

  // ----------------------------------------
  // Per-channel filter, latch and output monitor
  // ----------------------------------------
  reg [NCH-1:0] filt_state;
  reg [NCH-1:0] filt_prev;
  reg [NCH-1:0] edge_capture_flag;
  reg [NCH-1:0] output_fault_flag;
  reg [NCH-1:0] target_prev;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg [7:0] stab;
      reg [31:0] mis_cnt;
      // Step of two per sample, as the delay counts 100 us units
      wire [8:0] stab_next = {1'b0, stab} + 9'h002;
      wire mismatch = channel_direction_mask[g] & (pin_sync[g] != out_target[g]);
      always @(posedge clk) begin
        if (sys_rst) begin
          stab <= 8'h00;
          filt_state[g] <= 1'b0;
          filt_prev[g] <= 1'b0;
        end else if (delay_eff == 8'h00) begin
          stab <= 8'h00;
          filt_state[g] <= pin_sync[g]; // R8
          if (sample_tick)
            filt_prev[g] <= filt_state[g];
        end else if (sample_tick) begin
          filt_prev[g] <= filt_state[g];
          if (pin_sync[g] == filt_state[g]) begin
            stab <= 8'h00; // R5
          end else if (stab_next >= {1'b0, delay_eff}) begin
            stab <= 8'h00;
            filt_state[g] <= pin_sync[g]; // R5
          end else begin
            stab <= stab_next[7:0]; // R6
          end
        end
      end

      // Reset-dominant edge capture
      always @(posedge clk) begin
        if (sys_rst)
          edge_capture_flag[g] <= 1'b0;
        else if (edge_capture_ack[g])
          edge_capture_flag[g] <= 1'b0; // R10 R11
        else if (sample_tick & filt_state[g] & ~filt_prev[g])
          edge_capture_flag[g] <= 1'b1; // R9
      end

      // Output monitor: mismatch must persist before a fault is flagged
      always @(posedge clk) begin
        if (sys_rst) begin
          mis_cnt <= 32'h00000000;
          output_fault_flag[g] <= 1'b0;
          target_prev[g] <= 1'b0;
        end else begin
          target_prev[g] <= out_target[g];
          if (target_prev[g] != out_target[g] || !mismatch) begin
            mis_cnt <= 32'h00000000; // R21 R20
            if (target_prev[g] != out_target[g])
              output_fault_flag[g] <= 1'b0; // R21
          end else if (mis_cnt == FAULT_CYCLES - 1) begin
            output_fault_flag[g] <= 1'b1; // R22
          end else begin
            mis_cnt <= mis_cnt + 32'h00000001; // R20
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Fault change notification
  // ----------------------------------------
  reg [NCH-1:0] fault_seen;
  always @(posedge clk) begin
    if (sys_rst) begin
      fault_seen <= {NCH{1'b0}};
      fault_event <= 1'b0;
    end else begin
      fault_seen <= output_fault_flag;
      fault_event <= |(fault_seen ^ output_fault_flag); // R23
    end
  end

  // ----------------------------------------
  // Counter channels
  // ----------------------------------------
  // Counter inputs are channels 1 and 2; gate mode only on one channel
  wire gate_on1 = ccfg1[`DMIOC_CCFG_GATE_BIT];
  wire gate_on2 = ccfg2[`DMIOC_CCFG_GATE_BIT] & ~gate_on1; // R19
  wire [1:0] gate_on = {gate_on2, gate_on1}; // R12
  // Clear bit holds the counter at zero while it stays set
  wire [1:0] clr_req = {ccfg2[`DMIOC_CCFG_CLR_BIT], ccfg1[`DMIOC_CCFG_CLR_BIT]};
  reg [1:0] cnt_prev;
  reg [31:0] ref_cnt;
  wire ref_tick = (ref_cnt == GATE_REF_CYCLES - 1);
  reg [15:0] event_cnt [0:1];
  reg [15:0] gate_run [0:1];
  reg [15:0] gate_result [0:1];
  always @(posedge clk) begin
    if (sys_rst) begin
      ref_cnt <= 32'h00000000;
      cnt_prev <= 2'b00;
    end else begin
      ref_cnt <= ref_tick ? 32'h00000000 : ref_cnt + 32'h00000001; // R15
      cnt_prev <= pin_sync[1:0];
    end
  end

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_cnt
      wire fall = cnt_prev[g] & ~pin_sync[g];
      wire rise = ~cnt_prev[g] & pin_sync[g];
      always @(posedge clk) begin
        if (sys_rst) begin
          event_cnt[g] <= `DMIOC_RST_WORD; // R26
          gate_run[g] <= `DMIOC_RST_WORD;
          gate_result[g] <= `DMIOC_RST_WORD;
        end else if (clr_req[g]) begin
          event_cnt[g] <= `DMIOC_RST_WORD;
          gate_run[g] <= `DMIOC_RST_WORD;
          gate_result[g] <= `DMIOC_RST_WORD;
        end else if (!gate_on[g]) begin
          // Free wrap; software takes differences across snapshots
          if (fall)
            event_cnt[g] <= event_cnt[g] + 16'h0001; // R13 R26
        end else begin
          if (rise)
            gate_run[g] <= `DMIOC_RST_WORD; // R15
          else if (pin_sync[g] & ref_tick & gate_run[g] != `DMIOC_GATE_SAT)
            gate_run[g] <= gate_run[g] + 16'h0001; // R15 R16
          // Result holds the last finished gate until the next fall
          if (fall)
            gate_result[g] <= gate_run[g]; // R17 R16
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Network-cycle snapshot
  // ----------------------------------------
  // Fixed delay from the cycle mark keeps snapshot timing deterministic
  reg [15:0] ofs_cnt;
  reg ofs_run;
  wire snap = ofs_run & (ofs_cnt == SAMPLE_OFFSET - 1);
  // Snapshots hold until the next frame so late reads stay consistent
  reg [NCH-1:0] snap_raw;
  reg [NCH-1:0] snap_filt;
  reg [15:0] snap_cnt1;
  reg [15:0] snap_cnt2;
  always @(posedge clk) begin
    if (sys_rst) begin
      ofs_cnt <= 16'h0000;
      ofs_run <= 1'b0;
      snap_raw <= {NCH{1'b0}};
      snap_filt <= {NCH{1'b0}};
      snap_cnt1 <= `DMIOC_RST_WORD;
      snap_cnt2 <= `DMIOC_RST_WORD;
    end else begin
      if (net_cycle_mark) begin
        ofs_run <= 1'b1;
        ofs_cnt <= 16'h0000;
      end else if (snap) begin
        ofs_run <= 1'b0;
      end else if (ofs_run) begin
        ofs_cnt <= ofs_cnt + 16'h0001;
      end
      if (snap) begin
        snap_raw <= pin_sync; // R2
        snap_filt <= filt_state; // R3
        snap_cnt1 <= gate_on1 ? gate_result[0] : event_cnt[0]; // R14
        snap_cnt2 <= gate_on2 ? gate_result[1] : event_cnt[1]; // R14
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Held in a flop like every other read source
  reg supply_window_flag;
  always @(posedge clk) begin
    if (sys_rst)
      supply_window_flag <= 1'b0;
    else
      supply_window_flag <= sup_sync[0] | sup_sync[1]; // R24
  end
  reg [15:0] next_rdata;
  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `DMIOC_OFS_INPUT: next_rdata[NCH-1:0] = snap_filt;
      `DMIOC_OFS_RAW: next_rdata[NCH-1:0] = snap_raw;
      `DMIOC_OFS_OUTPUT: next_rdata[NCH-1:0] = out_target;
      `DMIOC_OFS_COUNT1: next_rdata = snap_cnt1;
      `DMIOC_OFS_COUNT2: next_rdata = snap_cnt2;
      `DMIOC_OFS_DIR: next_rdata[NCH-1:0] = channel_direction_mask;
      `DMIOC_OFS_FILTER: next_rdata[7:0] = filter_delay;
      `DMIOC_OFS_CCFG1: next_rdata[7:0] = ccfg1;
      `DMIOC_OFS_CCFG2: next_rdata[7:0] = ccfg2;
      `DMIOC_OFS_LATCH: next_rdata[NCH-1:0] = edge_capture_flag;
      `DMIOC_OFS_ACK: next_rdata[NCH-1:0] = edge_capture_ack;
      `DMIOC_OFS_FAULT: next_rdata[NCH-1:0] = output_fault_flag;
      `DMIOC_OFS_SUPPLY: next_rdata[0] = supply_window_flag;
      // Unmapped offsets read as zero so probing is harmless
      default: next_rdata = 16'h0000;
    endcase
  end

  // Read data stands one cycle only; idle cycles return zero
  always @(posedge clk) begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= 16'h0000;
  end

endmodule // dmioc_unit

// file: sim/dmioc_net_mgr.sv
// Network manager model issuing the cyclic frame mark
`timescale 1ns/1ps
module dmioc_net_mgr #(
  parameter PERIOD = 60
) (
  input wire clk,
  input wire sys_rst,
  output reg net_cycle_mark
);
  integer cnt;
  // Period kept well above the snapshot offset so each snapshot completes
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt <= 0;
      net_cycle_mark <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      net_cycle_mark <= (cnt == PERIOD - 1);
    end
  end
endmodule // dmioc_net_mgr

// file: sim/dmioc_unit_assertions.sv
// Port checker for the mixed digital I/O and counter unit
`timescale 1ns/1ps
`include "dmioc_consts.vh"
module dmioc_chk #(
  parameter NCH = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [13:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire net_cycle_mark,
  input wire [NCH-1:0] io_pin_in,
  input wire [NCH-1:0] io_pin_out,
  input wire [NCH-1:0] io_pin_oe,
  input wire supply_under,
  input wire supply_over,
  input wire fault_event
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Bus, direction and supply relations
  // ----------------------------------------
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  hole_read_a: assert property (reg_rd && reg_addr == 14'h0100 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  oe_write_a: assert property (
    reg_wr && reg_addr == `DMIOC_OFS_DIR |=> io_pin_oe == $past(reg_wdata[NCH-1:0]))
    else $error("direction write not applied");
  oe_source_a: assert property (
    $changed(io_pin_oe) |-> $past(reg_wr && reg_addr == `DMIOC_OFS_DIR))
    else $error("direction changed without write");
  out_write_a: assert property (
    reg_wr && reg_addr == `DMIOC_OFS_OUTPUT
    |=> io_pin_out == ($past(reg_wdata[NCH-1:0]) & io_pin_oe))
    else $error("output target not driven");
  out_masked_a: assert property ((io_pin_out & ~io_pin_oe) == {NCH{1'b0}})
    else $error("input channel driven");
  supply_in_a: assert property (
    (!supply_under && !supply_over)[*5] ##0 (reg_rd && reg_addr == `DMIOC_OFS_SUPPLY)
    |=> reg_rdata == 16'h0000)
    else $error("supply flag set inside window");
  supply_out_a: assert property (
    (supply_under || supply_over)[*5] ##0 (reg_rd && reg_addr == `DMIOC_OFS_SUPPLY)
    |=> reg_rdata == 16'h0001)
    else $error("supply flag clear outside window");
  cover property (fault_event);
  cover property (net_cycle_mark ##[1:30] reg_rd);
  cover property (reg_wr && reg_addr == `DMIOC_OFS_ACK && reg_wdata != 16'h0000);
endmodule // dmioc_chk
bind dmioc_unit dmioc_chk #(.NCH(NCH)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .net_cycle_mark(net_cycle_mark), .io_pin_in(io_pin_in),
  .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .supply_under(supply_under),
  .supply_over(supply_over), .fault_event(fault_event));

// file: sim/tb_top.sv
// Self-checking bench for the mixed digital I/O and counter unit
`timescale 1ns/1ps
`include "dmioc_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [13:0] reg_addr = 14'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic supply_under = 1'b0;
  logic supply_over = 1'b0;
  logic [7:0] fld = 8'h00;
  logic [7:0] shorted = 8'h00;
  logic [7:0] dir, tgt;
  logic [15:0] rd;
  logic [13:0] ofs [5] = '{`DMIOC_OFS_OUTPUT, `DMIOC_OFS_DIR, `DMIOC_OFS_COUNT1,
    `DMIOC_OFS_LATCH, `DMIOC_OFS_FAULT};
  integer n_errors = 0, tests_run = 0, seed = 4, nfe = 0, i, n, e;
  time t0;
  integer m_evt = 0;
  logic m_prev0 = 1'b0;
  wire [15:0] reg_rdata;
  wire net_cycle_mark, fault_event;
  wire [7:0] io_pin_in, io_pin_out, io_pin_oe;
  // Field side: outputs read back unless shorted, inputs from the sensor value
  assign io_pin_in = (io_pin_out & io_pin_oe & ~shorted) | (fld & ~io_pin_oe);
  always #5 clk = ~clk;
  always @(posedge clk) if (fault_event === 1'b1) nfe = nfe + 1;
  // Rule model of counter 1 in event mode: falls on its field input, 16-bit wrap
  always @(posedge clk) begin
    if (m_prev0 && !fld[0]) m_evt = (m_evt + 1) % 65536;
    m_prev0 = fld[0];
  end
  dmioc_unit #(.TICK_CYCLES(20), .GATE_REF_CYCLES(4), .FAULT_CYCLES(8)) DUT (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .net_cycle_mark(net_cycle_mark),
    .io_pin_in(io_pin_in), .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe),
    .supply_under(supply_under), .supply_over(supply_over), .fault_event(fault_event));
  dmioc_net_mgr #(.PERIOD(60)) u_mgr (.clk(clk), .sys_rst(sys_rst),
    .net_cycle_mark(net_cycle_mark));
  // ----------------------------------------
  // Bus and wait helpers
  // ----------------------------------------
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [13:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic chk_reg(input logic [13:0] a, input logic [15:0] x);
    rd_reg(a);
    `CHK(rd, x)
  endtask
  task automatic set_fld(input logic [7:0] v, input integer k);
    @(posedge clk);
    fld <= v;
    repeat (k) @(posedge clk);
  endtask
  // Bounded wait for a frame mark, then k more cycles
  task automatic snap(input integer k);
    integer t;
    for (t = 0; t < 200 && net_cycle_mark !== 1'b1; t++) @(posedge clk) #1;
    if (t == 200) begin
      n_errors++;
      give_verdict;
    end
    repeat (k) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    wr(`DMIOC_OFS_LATCH, 16'h00FF);
    for (i = 0; i < 5; i++) chk_reg(ofs[i], 16'h0000);
    chk_reg(14'h0100, 16'h0000);
    dir = 8'($random(seed));
    tgt = 8'($random(seed));
    wr(`DMIOC_OFS_DIR, {8'h00, dir});
    wr(`DMIOC_OFS_OUTPUT, {8'h00, tgt});
    chk_reg(`DMIOC_OFS_DIR, {8'h00, dir});
    chk_reg(`DMIOC_OFS_OUTPUT, {8'h00, tgt});
    `CHK(io_pin_out, tgt & dir)
    `CHK(io_pin_oe, dir)
    wr(`DMIOC_OFS_OUTPUT, 16'h0000);
    wr(`DMIOC_OFS_DIR, 16'h0000);
    wr(`DMIOC_OFS_FILTER, 16'h0000);
    wr(`DMIOC_OFS_ACK, 16'h00FF);
    wr(`DMIOC_OFS_ACK, 16'h0000);
    snap(0);
    set_fld(8'hA5, 8);
    chk_reg(`DMIOC_OFS_RAW, 16'h0000);
    repeat (6) @(posedge clk);
    chk_reg(`DMIOC_OFS_RAW, 16'h00A5);
    chk_reg(`DMIOC_OFS_INPUT, 16'h00A5);
    repeat (50) @(posedge clk);
    chk_reg(`DMIOC_OFS_LATCH, 16'h00A5);
    wr(`DMIOC_OFS_ACK, 16'h0005);
    chk_reg(`DMIOC_OFS_LATCH, 16'h00A0);
    set_fld(8'hA4, 50);
    set_fld(8'hA5, 50);
    chk_reg(`DMIOC_OFS_LATCH, 16'h00A0);
    wr(`DMIOC_OFS_ACK, 16'h0000);
    chk_reg(`DMIOC_OFS_LATCH, 16'h00A0);
    wr(`DMIOC_OFS_FILTER, 16'h0004);
    set_fld(8'hA7, 30);
    set_fld(8'hA5, 100);
    snap(18);
    chk_reg(`DMIOC_OFS_INPUT, 16'h00A5);
    set_fld(8'hA7, 200);
    snap(18);
    chk_reg(`DMIOC_OFS_INPUT, 16'h00A7);
    chk_reg(`DMIOC_OFS_LATCH, 16'h00A2);
    wr(`DMIOC_OFS_FILTER, 16'h0000);
    wr(`DMIOC_OFS_CCFG1, 16'h0020);
    m_evt = 0;
    wr(`DMIOC_OFS_CCFG1, 16'h0000);
    n = 3 + {$random(seed)} % 6;
    for (i = 0; i < n; i++) begin
      set_fld(8'hA6, 10);
      set_fld(8'hA7, 10);
    end
    snap(18);
    chk_reg(`DMIOC_OFS_COUNT1, 16'(n));
    `CHK(rd, 16'(m_evt))
    wr(`DMIOC_OFS_CCFG1, 16'h0001);
    set_fld(8'hA6, 50);
    for (i = 1; i < 3; i++) begin
      set_fld(8'hA7, 0);
      t0 = $time;
      repeat (40 * i) @(posedge clk);
      if (i == 2) begin
        snap(18);
        chk_reg(`DMIOC_OFS_COUNT1, rd);
      end
      set_fld(8'hA6, 0);
      e = ($time - t0) / 40;
      snap(18);
      rd_reg(`DMIOC_OFS_COUNT1);
      `CHK(rd >= e - 1 && rd <= e + 1, 1'b1)
      set_fld(8'hA6, 30);
    end
    // Gate asked on both channels: channel 2 must stay an event counter
    wr(`DMIOC_OFS_CCFG2, 16'h0020);
    wr(`DMIOC_OFS_CCFG2, 16'h0001);
    set_fld(8'hA4, 10);
    set_fld(8'hA6, 10);
    snap(18);
    chk_reg(`DMIOC_OFS_COUNT2, 16'h0001);
    wr(`DMIOC_OFS_CCFG1, 16'h0000);
    wr(`DMIOC_OFS_DIR, 16'h0010);
    shorted <= 8'h10;
    nfe = 0;
    wr(`DMIOC_OFS_OUTPUT, 16'h0010);
    repeat (30) @(posedge clk);
    chk_reg(`DMIOC_OFS_FAULT, 16'h0010);
    `CHK(nfe, 1)
    wr(`DMIOC_OFS_OUTPUT, 16'h0000);
    repeat (5) @(posedge clk);
    chk_reg(`DMIOC_OFS_FAULT, 16'h0000);
    `CHK(nfe, 2)
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {supply_over, supply_under} <= 2'(i);
      repeat (6) @(posedge clk);
      chk_reg(`DMIOC_OFS_SUPPLY, {15'h0000, i != 0});
    end
    give_verdict;
  end
  // Hang guard well above the run time of the scenarios
  initial begin
    #500000;
    n_errors++;
    give_verdict;
  end
endmodule // tb_top
